// [logic/term_io_ports.sv]
// Terminal I/O board ports: serial, status, flags, keyboard, printer
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tio_params.svh"
module term_io_ports
	import tio_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             irq_o,
	// Processor side
	output logic      [3:0]  ts_o,
	input  wire logic [7:0]  acc_i,
	input  wire logic [7:0]  bus_in_i,
	output logic      [7:0]  bus_out_o,
	output logic             bus_oe_o,
	input  wire logic [1:0]  src_sel_i,
	input  wire logic        act_a_i,
	input  wire logic        act_b_i,
	input  wire logic        tx_load_i,
	output logic             key_up_o,
	output logic             key_hit_o,
	// Serial adapter slot
	output logic             txd_o,
	input  wire logic        rxd_i,
	input  wire logic [2:0]  modem_stat_i,
	output logic      [2:0]  modem_ctl_o,
	// Terminal conditions and flags
	input  wire logic [2:0]  term_stat_i,
	input  wire logic        prn_busy_i,
	output logic      [7:0]  misc_o,
	// Keyboard matrix
	output logic      [9:0]  key_col_o,
	input  wire logic [7:0]  key_row_i,
	input  wire logic        capitals_lock_key_i,
	// Printer
	output logic      [7:0]  prn_data_o,
	output logic             prn_strobe_o
);
	// ==========================================
	// Pin synchronisers
	logic [7:0]  row_s1_reg, row_s2_reg;
	logic [7:0]  pin_s1_reg, pin_s2_reg;
	logic        rxd_s1_reg, rxd_s2_reg;

	// Two flops before any reader
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			row_s1_reg <= 8'h00;
			row_s2_reg <= 8'h00;
			pin_s1_reg <= 8'h00;
			pin_s2_reg <= 8'h00;
			rxd_s1_reg <= 1'b1;
			rxd_s2_reg <= 1'b1;
		end else begin
			row_s1_reg <= key_row_i;
			row_s2_reg <= row_s1_reg;
			pin_s1_reg <= {term_stat_i, capitals_lock_key_i, prn_busy_i, modem_stat_i};
			pin_s2_reg <= pin_s1_reg;
			rxd_s1_reg <= rxd_i;
			rxd_s2_reg <= rxd_s1_reg;
		end
	end

	// ==========================================
	// Time states and count chain
	logic [3:0]  ts_reg;
	logic [1:0]  sub_reg;
	logic [7:0]  baud_reg, chain_reg;
	logic        tick_reg;
	wire         last_edge = (ts_reg == `TS_LAST) && (sub_reg == `SUB_LAST);
	// Ends at or past the divisor, so lowering it never forces a full wrap
	wire         chain_end = last_edge && (chain_reg >= baud_reg);

	// Each state lasts TS_CYC clocks; transfers act on the last clock of T9
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ts_reg    <= `TS_FIRST;
			sub_reg   <= 2'h0;
			chain_reg <= 8'h00;
			tick_reg  <= 1'b0;
		end else begin
			sub_reg   <= (sub_reg == `SUB_LAST) ? 2'h0 : sub_reg + 2'h1;
			if (sub_reg == `SUB_LAST)
				ts_reg <= (ts_reg == `TS_LAST) ? `TS_FIRST : ts_reg + 4'h1;
			if (last_edge)
				chain_reg <= chain_end ? 8'h00 : chain_reg + 8'h01;
			tick_reg  <= chain_end;
		end
	end

	assign ts_o = ts_reg;

	// ==========================================
	// Strobe decode; A alone modem, B alone misc, both printer
	wire ld_modem = last_edge && act_a_i && !act_b_i;
	wire ld_misc  = last_edge && !act_a_i && act_b_i;
	wire ld_prn   = last_edge && act_a_i && act_b_i;
	wire ld_tx    = last_edge && tx_load_i;
	wire rd_rx    = last_edge && (src_sel_i == `SRC_RX);

	// ==========================================
	// Serial byte path
	logic [7:0]  rx_data, rx_byte_reg;
	logic        rx_valid, rx_full_reg, tx_busy, tx_done;

	ser_tx u_tx (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.tick_i (tick_reg),
		.load_i (ld_tx),
		.data_i (bus_in_i),
		.txd_o  (txd_o),
		.busy_o (tx_busy),
		.done_o (tx_done)
	);

	ser_rx u_rx (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.tick_i  (tick_reg),
		.rxd_i   (rxd_s2_reg),
		.data_o  (rx_data),
		.valid_o (rx_valid)
	);

	// Received byte waits for the processor; a new byte wins over the read
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_byte_reg <= 8'h00;
			rx_full_reg <= 1'b0;
		end else begin
			if (rx_valid)
				rx_byte_reg <= rx_data;
			rx_full_reg <= rx_valid || (rx_full_reg && !rd_rx);
		end
	end

	// ==========================================
	// Holding registers for flags and printer
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			modem_ctl_o  <= 3'h0;
			misc_o       <= 8'h00;
			prn_data_o   <= 8'h00;
			prn_strobe_o <= 1'b0;
		end else begin
			if (ld_modem)
				modem_ctl_o <= acc_i[2:0];
			if (ld_misc)
				misc_o <= acc_i;
			if (ld_prn)
				prn_data_o <= acc_i; // Passed untouched
			prn_strobe_o <= ld_prn;
		end
	end

	// ==========================================
	// Status port and tri-state bus
	// Modem lines low three bits, then printer busy, capitals lock, terminal lines top three
	// Eight pin lines only; receive-full reads back in the state word
	wire [7:0] status_word = pin_s2_reg;
	wire       sel_status  = (src_sel_i == `SRC_STATUS);
	wire       sel_rx      = (src_sel_i == `SRC_RX);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_out_o <= 8'h00;
			bus_oe_o  <= 1'b0;
		end else begin
			bus_oe_o  <= sel_status || sel_rx; // Off when not the source
			bus_out_o <= sel_status ? status_word : (sel_rx ? rx_byte_reg : 8'h00);
		end
	end

	// ==========================================
	// Keyboard: key number = column x 8 + row
	wire       key_valid = (acc_i[6:0] < `KEY_COUNT) && !acc_i[7];
	wire       key_down  = key_valid && row_s2_reg[acc_i[2:0]];
	wire [9:0] col_next;

	genvar c;
	generate
		for (c = 0; c < `KEY_COLS; c++) begin : g_col
			assign col_next[c] = key_valid && (acc_i[6:3] == 4'(c));
		end
	endgenerate

	// Rows lag the column drive by the synchroniser; poll loop allows it
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			key_col_o <= 10'h000;
			key_up_o  <= 1'b1;
			key_hit_o <= 1'b0;
		end else begin
			key_col_o <= col_next;
			key_up_o  <= !key_down;
			key_hit_o <= key_down; // Branch condition
		end
	end

	// ==========================================
	// Avalon slave: one wait cycle, answer on the second edge
	logic [2:0]  irq_stat_reg, irq_mask_reg;
	logic        wait_reg;
	wire         req      = avs_read_i || avs_write_i;
	wire         done     = req && !wait_reg;
	wire [2:0]   idx      = avs_address_i[4:2];
	wire         wr_mask  = done && avs_write_i && (idx == `A_MASK);
	wire         wr_baud  = done && avs_write_i && (idx == `A_BAUD);
	wire         rd_irq   = done && avs_read_i && (idx == `A_IRQ);
	wire [2:0]   irq_set  = {key_down && !key_hit_o, tx_done, rx_valid};
	wire [31:0]  rd_next  = (idx == `A_IRQ)   ? {29'h0, irq_stat_reg} :
				(idx == `A_MASK)  ? {29'h0, irq_mask_reg} :
				(idx == `A_BAUD)  ? {24'h0, baud_reg} :
				(idx == `A_STATE) ? {21'h0, rx_full_reg, key_up_o, tx_busy, status_word} :
				(idx == `A_FLAGS) ? {21'h0, modem_ctl_o, misc_o} : 32'h0;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_reg       <= 1'b1;
			avs_readdata_o <= 32'h0;
		end else begin
			wait_reg       <= !(req && wait_reg);
			avs_readdata_o <= rd_next;
		end
	end

	assign avs_waitrequest_o = wait_reg;

	// Sticky events; set wins over the read clear
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
			baud_reg     <= `BAUD_RST;
			irq_o        <= 1'b0;
		end else begin
			// Clear only what the read returned; a later event survives
			irq_stat_reg <= irq_set | (irq_stat_reg & ~(rd_irq ? avs_readdata_o[2:0] : 3'h0));
			if (wr_mask)
				irq_mask_reg <= avs_writedata_i[2:0];
			if (wr_baud)
				baud_reg <= avs_writedata_i[7:0]; // Serial rate divisor
			irq_o <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	AST_BUS_OFF: assert property ((src_sel_i == `SRC_NONE) |=> !bus_oe_o)
		else $error("bus driven while not selected");
	AST_STATUS_SRC: assert property (sel_status |=> bus_oe_o &&
		bus_out_o == $past(status_word))
		else $error("status port not on bus");
	AST_RX_SRC: assert property (sel_rx |=> bus_out_o == $past(rx_byte_reg))
		else $error("received byte not on bus");
	AST_MODEM_LOAD: assert property (ld_modem |=> modem_ctl_o == $past(acc_i[2:0]))
		else $error("modem flags not loaded");
	AST_MISC_HOLD: assert property (!ld_misc |=> $stable(misc_o))
		else $error("misc flags changed without strobe");
	AST_KEY_NONE: assert property (!key_valid |=> key_up_o && !key_hit_o)
		else $error("key reported for invalid number");
	AST_KEY_HIT: assert property (key_down |=> key_hit_o && !key_up_o)
		else $error("pressed key not reported");
	AST_TS_WRAP: assert property (last_edge |=> ts_reg == `TS_FIRST ##2 ts_reg == `TS_FIRST
		##1 ts_reg == 4'h1)
		else $error("time state cycle broken");
	AST_TICK_ALIGN: assert property (tick_reg |-> $past(last_edge))
		else $error("serial tick off the count chain");
	AST_TX_IDLE: assert property (!tx_busy && !$past(tx_busy) |-> txd_o)
		else $error("line not marking while idle");
	AST_BUS_ANSWER: assert property (req && wait_reg |=> !avs_waitrequest_o ##1
		avs_waitrequest_o) // Bus answer timing
		else $error("slave answer timing wrong");


	// ==========================================
	// Holding registers, printer and keyboard
	AST_MISC_LOAD: assert property (ld_misc |=> misc_o == $past(acc_i))
		else $error("misc flags not loaded");
	AST_MODEM_HOLD: assert property (!ld_modem |=> $stable(modem_ctl_o))
		else $error("modem flags changed without strobe");
	AST_PRN_PASS: assert property (ld_prn |=> prn_strobe_o &&
		prn_data_o == $past(acc_i))
		else $error("printer byte not passed");
	AST_PRN_PULSE: assert property (!ld_prn |=> !prn_strobe_o)
		else $error("printer strobe without load");
	AST_KEY_COL: assert property (key_valid |=> $onehot(key_col_o))
		else $error("column drive not one-hot");
	AST_KEY_COL_OFF: assert property (!key_valid |=> key_col_o == 10'h000)
		else $error("column driven for invalid number");

	// Serial path, bus and interrupts
	AST_TX_START: assert property (ld_tx && !tx_busy |=> tx_busy)
		else $error("transmitter ignored a load while idle");
	AST_RX_FULL: assert property (rx_valid |=> rx_full_reg)
		else $error("received byte not held");
	AST_BUS_OTHER: assert property (!sel_status && !sel_rx |=> !bus_oe_o)
		else $error("bus driven by unused source code");
	AST_IRQ_STICKY: assert property ((|irq_set) |=>
		(irq_stat_reg & $past(irq_set)) == $past(irq_set))
		else $error("event not latched");
	AST_IRQ_OUT: assert property ((|(irq_stat_reg & irq_mask_reg)) |=> irq_o)
		else $error("unmasked event without interrupt");

	// Cover helper: a taken load awaiting its done pulse; a frame outlasts any short range
	logic        cov_tx_armed_reg;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			cov_tx_armed_reg <= 1'b0;
		else if (ld_tx && !tx_busy)
			cov_tx_armed_reg <= 1'b1;
		else if (tx_done)
			cov_tx_armed_reg <= 1'b0;
	end

	COV_RX_BYTE: cover property (rx_valid ##[1:40] rd_rx);
	COV_TX_DONE: cover property (cov_tx_armed_reg && tx_done);
	COV_KEY_HIT: cover property (key_valid ##1 key_hit_o);
	COV_IRQ: cover property (irq_o ##[1:4] rd_irq);
endmodule : term_io_ports

// [logic/tio_params.svh]
// Constants for the terminal port block: timing, offsets, fields, resets
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH
// ==========================================
// Timing
`define CLK_NS       20
`define TS_NS        65
`define TS_CYC       ((`TS_NS) / (`CLK_NS))
`define TS_LAST      4'h9
`define TS_FIRST     4'h0
`define SUB_LAST     2'(`TS_CYC - 1)
// ==========================================
// Register word indexes (byte address = 4 x index)
`define A_IRQ        3'h0
`define A_MASK       3'h1
`define A_BAUD       3'h2
`define A_STATE      3'h3
`define A_FLAGS      3'h4
`define BAUD_RST     8'h0F
`define IRQ_RX       0
`define IRQ_TX       1
`define IRQ_KEY      2
// ==========================================
// Bus source codes and keyboard geometry
`define SRC_NONE     2'h0
`define SRC_STATUS   2'h1
`define SRC_RX       2'h2
`define KEY_COUNT    7'h50
`define KEY_COLS     10
// ==========================================
// Serial framing, 16 samples a bit
`define OVS_LAST     4'hF
`define OVS_HALF     4'h7
`define BIT_LAST     3'h7
`endif

// [logic/tio_pkg.sv]
// Types shared by the terminal port block
package tio_pkg;
	typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} ser_state_t;
endpackage : tio_pkg

// [logic/ser_tx.sv]
// Asynchronous serial transmitter, one start, eight data, one stop bit
`timescale 1ns/1ps
`include "tio_params.svh"
module ser_tx
	import tio_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic       tick_i,
	input  wire logic       load_i,
	input  wire logic [7:0] data_i,
	output logic            txd_o,
	output logic            busy_o,
	output logic            done_o
);
	ser_state_t state_reg;
	logic [3:0] os_reg;
	logic [2:0] bit_reg;
	logic [7:0] sh_reg;
	wire        bit_end = tick_i && (os_reg == `OVS_LAST);

	// ==========================================
	// Shifter; a load while busy is ignored
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= S_IDLE;
			os_reg    <= 4'h0;
			bit_reg   <= 3'h0;
			sh_reg    <= 8'h00;
			txd_o     <= 1'b1;
			done_o    <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (tick_i)
				os_reg <= os_reg + 4'h1;
			unique case (state_reg)
				S_IDLE: begin
					txd_o <= 1'b1; // Idle line is marking
					if (load_i) begin
						sh_reg    <= data_i;
						state_reg <= S_START;
						os_reg    <= 4'h0;
					end
				end
				S_START: begin
					txd_o <= 1'b0;
					if (bit_end) begin
						state_reg <= S_DATA;
						bit_reg   <= 3'h0;
					end
				end
				S_DATA: begin
					txd_o <= sh_reg[0]; // LSB first
					if (bit_end) begin
						sh_reg  <= {1'b0, sh_reg[7:1]};
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == `BIT_LAST)
							state_reg <= S_STOP;
					end
				end
				S_STOP: begin
					txd_o <= 1'b1;
					if (bit_end) begin
						state_reg <= S_IDLE;
						done_o    <= 1'b1;
					end
				end
			endcase
		end
	end

	assign busy_o = (state_reg != S_IDLE);
endmodule : ser_tx

// [logic/ser_rx.sv]
// Asynchronous serial receiver, 16 samples a bit, mid-bit decision
`timescale 1ns/1ps
`include "tio_params.svh"
module ser_rx
	import tio_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic       tick_i,
	input  wire logic       rxd_i,
	output logic [7:0]      data_o,
	output logic            valid_o
);
	ser_state_t state_reg;
	logic [3:0] os_reg;
	logic [2:0] bit_reg;

	// ==========================================
	// Start is rechecked at half bit to reject glitches
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= S_IDLE;
			os_reg    <= 4'h0;
			bit_reg   <= 3'h0;
			data_o    <= 8'h00;
			valid_o   <= 1'b0;
		end else begin
			valid_o <= 1'b0;
			if (tick_i) begin
				os_reg <= os_reg + 4'h1;
				unique case (state_reg)
					S_IDLE: begin
						os_reg <= 4'h0;
						if (!rxd_i)
							state_reg <= S_START;
					end
					S_START: begin
						if (os_reg == `OVS_HALF) begin
							os_reg    <= 4'h0;
							bit_reg   <= 3'h0;
							state_reg <= rxd_i ? S_IDLE : S_DATA;
						end
					end
					S_DATA: begin
						if (os_reg == `OVS_LAST) begin
							data_o  <= {rxd_i, data_o[7:1]};
							bit_reg <= bit_reg + 3'h1;
							if (bit_reg == `BIT_LAST)
								state_reg <= S_STOP;
						end
					end
					S_STOP: begin
						if (os_reg == `OVS_LAST) begin
							valid_o   <= rxd_i; // Framing error drops the byte
							state_reg <= S_IDLE;
						end
					end
				endcase
			end
		end
	end
endmodule : ser_rx

// [tb/proc_model.sv]
// Processor-side model that raises micro-action and transmit-load strobes
`timescale 1ns/1ps
module proc_model (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic       go_i,
	input  wire logic [2:0] cmd_i,
	output logic            act_a_o,
	output logic            act_b_o,
	output logic            tx_load_o,
	output logic            busy_o
);
	// ==========================================
	// Strobe timing
	logic [4:0] cnt_reg;

	assign busy_o = (cnt_reg != 5'h00);

	// Held 30 clocks: exactly one end-of-T9 edge sees it, whatever the phase
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= 5'h00;
			{tx_load_o, act_b_o, act_a_o} <= 3'h0;
		end else if (go_i && cnt_reg == 5'h00) begin
			cnt_reg <= 5'h1E;
			{tx_load_o, act_b_o, act_a_o} <= cmd_i;
		end else if (cnt_reg == 5'h01) begin
			cnt_reg <= 5'h00;
			{tx_load_o, act_b_o, act_a_o} <= 3'h0;
		end else if (busy_o) begin
			cnt_reg <= cnt_reg - 5'h01;
		end
	end
endmodule : proc_model

// [tb/testbench.sv]
// Self-checking testbench for the terminal port block
`timescale 1ns/1ps
module testbench;
	// ==========================================
	// Stimulus and observed signals
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [4:0]  av_addr = 5'h00;
	logic        av_rd = 1'b0;
	logic        av_wr = 1'b0;
	logic [31:0] av_wdata = 32'h0;
	logic [7:0]  acc = 8'h00;
	logic [7:0]  bus_in = 8'hC3;
	logic [1:0]  src_sel = 2'h0;
	logic [2:0]  modem_stat = 3'h0;
	logic [2:0]  term_stat = 3'h0;
	logic        prn_busy = 1'b0;
	logic        caps = 1'b0;
	logic        go = 1'b0;
	logic [2:0]  cmd = 3'h0;
	logic        key_en = 1'b0;
	logic [6:0]  key_num = 7'h4F;
	int          n_fail = 0;
	int          checked = 0;
	int          strobe_cnt = 0;
	wire  [31:0] av_rdata;
	wire         av_wait, irq, bus_oe, act_a, act_b, tx_load, key_up, key_hit;
	wire         txd, prn_strobe, pm_busy;
	wire  [3:0]  ts;
	wire  [7:0]  bus_out, misc, prn_data, key_row;
	wire  [2:0]  modem_ctl;
	wire  [9:0]  key_col;

	always #10 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (prn_strobe === 1'b1) strobe_cnt++;
	// Key matrix: the pressed key pulls its row only while its column is driven
	assign key_row = (key_en && key_col[key_num[6:3]]) ? (8'h01 << key_num[2:0]) : 8'h00;

	term_io_ports u_term_io_ports (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(av_addr),
		.avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
		.avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait), .irq_o(irq), .ts_o(ts),
		.acc_i(acc), .bus_in_i(bus_in), .bus_out_o(bus_out), .bus_oe_o(bus_oe),
		.src_sel_i(src_sel), .act_a_i(act_a), .act_b_i(act_b), .tx_load_i(tx_load),
		.key_up_o(key_up), .key_hit_o(key_hit), .txd_o(txd), .rxd_i(txd),
		.modem_stat_i(modem_stat), .modem_ctl_o(modem_ctl), .term_stat_i(term_stat),
		.prn_busy_i(prn_busy), .misc_o(misc), .key_col_o(key_col), .key_row_i(key_row),
		.capitals_lock_key_i(caps), .prn_data_o(prn_data), .prn_strobe_o(prn_strobe));
	proc_model u_proc_model (.mclk_i(mclk_i), .nrst_i(nrst_i), .go_i(go), .cmd_i(cmd),
		.act_a_o(act_a), .act_b_o(act_b), .tx_load_o(tx_load), .busy_o(pm_busy));

	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// Request held until waitrequest is sampled low; the watchdog bounds the wait
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk_i);
		av_addr <= a;
		av_wdata <= d;
		av_rd <= !wr;
		av_wr <= wr;
		do @(posedge mclk_i); while (av_wait !== 1'b0);
		q = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd_check(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rd_check

	task automatic pulse(input logic [2:0] c);
		@(posedge mclk_i);
		go <= 1'b1;
		cmd <= c;
		@(posedge mclk_i);
		go <= 1'b0;
	endtask : pulse

	task automatic act(input logic [2:0] c);
		pulse(c);
		do @(posedge mclk_i); while (pm_busy !== 1'b0);
		repeat (3) @(posedge mclk_i);
	endtask : act

	// ==========================================
	// Scenarios
	task automatic t_regs;
		rd_check(5'h08, 32'h0F);
		rd_check(5'h04, 32'h0);
		rd_check(5'h14, 32'h0);
		wr(5'h08, 32'h123);
		rd_check(5'h08, 32'h23);
		wr(5'h10, 32'hFF);
		rd_check(5'h10, 32'h0);
		wr(5'h08, 32'h0);
	endtask : t_regs

	task automatic t_flags;
		acc <= 8'hFD;
		act(3'h1);
		check(modem_ctl, 32'h5);
		acc <= 8'hA5;
		act(3'h2);
		check(misc, 32'hA5);
		check(modem_ctl, 32'h5);
		acc <= 8'h96;
		act(3'h3);
		check(prn_data, 32'h96);
		check(strobe_cnt, 32'h1);
		check(misc, 32'hA5);
		rd_check(5'h10, 32'h5A5);
	endtask : t_flags

	task automatic t_status;
		// Time state 9 lasts three clocks, the cycle thirty
		while (ts !== 4'h9) @(posedge mclk_i);
		repeat (3) @(posedge mclk_i);
		check(ts, 32'h0);
		repeat (27) @(posedge mclk_i);
		check(ts, 32'h9);
		modem_stat <= 3'h5;
		term_stat <= 3'h6;
		prn_busy <= 1'b1;
		repeat (6) @(posedge mclk_i);
		check(bus_oe, 32'h0);
		src_sel <= 2'h1;
		repeat (3) @(posedge mclk_i);
		check(bus_oe, 32'h1);
		check(bus_out, 32'hCD);
		modem_stat <= 3'h2;
		repeat (6) @(posedge mclk_i);
		check(bus_out, 32'hCA);
		src_sel <= 2'h3;
		repeat (3) @(posedge mclk_i);
		check(bus_oe, 32'h0);
	endtask : t_status

	task automatic t_keys;
		int n;
		wr(5'h04, 32'h4);
		key_en <= 1'b1;
		n = 0;
		// Software-style poll: step the number until a pressed key answers
		while (n < 80) begin
			acc <= 8'(n);
			repeat (6) @(posedge mclk_i);
			if (key_hit === 1'b1) break;
			n++;
		end
		check(n, 32'h4F);
		check(key_col, 32'h200);
		check(key_up, 32'h0);
		check(irq, 32'h1);
		rd_check(5'h00, 32'h4);
		repeat (3) @(posedge mclk_i);
		check(irq, 32'h0);
		acc <= 8'h4E;
		repeat (6) @(posedge mclk_i);
		check(key_up, 32'h1);
		acc <= 8'h50;
		repeat (6) @(posedge mclk_i);
		check(key_up, 32'h1);
		acc <= 8'h00;
		repeat (6) @(posedge mclk_i);
	endtask : t_keys

	task automatic t_serial;
		bus_in <= 8'h3C;
		pulse(3'h4);
		while (txd !== 1'b0) @(posedge mclk_i);
		rd_check(5'h0C, 32'h3CA);
		repeat (237) @(posedge mclk_i);
		check(txd, 32'h0);
		// Data bits least significant first, 480 clocks each at divisor zero
		for (int i = 0; i < 8; i++) begin
			repeat (480) @(posedge mclk_i);
			check(txd, {31'h0, bus_in[i]});
		end
		repeat (480) @(posedge mclk_i);
		check(txd, 32'h1);
		bus_in <= 8'hC3;
		repeat (600) @(posedge mclk_i);
		check(irq, 32'h0);
		rd_check(5'h00, 32'h3);
		rd_check(5'h0C, 32'h6CA);
		src_sel <= 2'h2;
		repeat (3) @(posedge mclk_i);
		check(bus_oe, 32'h1);
		check(bus_out, 32'h3C);
		repeat (35) @(posedge mclk_i);
		rd_check(5'h0C, 32'h2CA);
		src_sel <= 2'h0;
	endtask : t_serial

	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (4) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_flags();
		t_status();
		t_keys();
		t_serial();
		stop_test();
	end

	// Whole run needs under 10000 clocks; four times that means a hang
	initial begin
		repeat (40000) @(posedge mclk_i);
		n_fail++;
		stop_test();
	end
endmodule : testbench
